/* File: hdl/branch_bit_set_decode.sv */
// Decoder and executor for relative branches and bit set in file register
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Opcode E7 branches when negative flag is clear
// - Opcode E5 branches when overflow flag is clear
// - Opcode E1 branches when zero flag is clear
// - Taken branch loads incremented counter plus twice signed 8-bit offset
// - Untaken branch one cycle; taken adds a cycle of no operation
// - Pattern 11010 always branches by twice 11-bit offset, two cycles
// - Pattern 1000 reads register, sets chosen bit, writes back in one cycle
// - Access bit 0 picks access bank, 1 uses bank select register
// - Access 0, extended set on, address up to 95 uses indexed offset
module branch_bit_set_decode (
    input  wire logic        clock_in,
    input  wire logic        srst_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [15:0] instr_word_in,
    input  wire logic        instr_valid_in,
    input  wire logic        negative_flag_in,
    input  wire logic        overflow_flag_in,
    input  wire logic        zero_flag_in,
    input  wire logic [11:0] index_base_in,
    input  wire logic [7:0]  mem_rdata_in,
    output logic      [3:0]  q_phase_out,
    output logic             fetch_take_out,
    output logic      [20:0] pc_out,
    output logic      [11:0] mem_addr_out,
    output logic             mem_rd_out,
    output logic             mem_wr_out,
    output logic      [7:0]  mem_wdata_out
);
    q_phase_if qif ();

    q_phase_gen u_phase (
        .clock_in (clock_in),
        .srst_in  (srst_in),
        .qif      (qif)
    );

    branch_bit_set_pkg::seq_state_t state_q;
    branch_bit_set_pkg::seq_state_t state_d;
    logic [15:0] ir_q;
    logic [15:0] ir_d;
    logic        have_q;
    logic        have_d;
    logic [20:0] pc_q;
    logic [20:0] pc_d;
    logic [20:0] target_q;
    logic [20:0] target_d;
    logic        taken_q;
    logic        taken_d;
    logic        take_q;
    logic        take_d;
    logic [11:0] maddr_q;
    logic [11:0] maddr_d;
    logic        mrd_q;
    logic        mrd_d;
    logic        mwr_q;
    logic        mwr_d;
    logic [7:0]  mwdata_q;
    logic [7:0]  mwdata_d;

    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        ext_q;
    logic        ext_d;
    logic [3:0]  bank_q;
    logic [3:0]  bank_d;
    logic        unknown_q;
    logic        unknown_d;

    logic        accept_w;
    logic        is_nn_w;
    logic        is_nov_w;
    logic        is_nz_w;
    logic        is_bra_w;
    logic        is_bsf_w;
    logic        cond_w;
    logic [7:0]  file_w;
    logic [7:0]  mask_w;
    logic [20:0] off8_w;
    logic [20:0] off11_w;
    logic [11:0] addr_w;
    logic        req_w;

    function automatic logic known_op(input logic [15:0] w);
        known_op = (w[15:8] == branch_bit_set_pkg::OP_NOT_NEG)
                || (w[15:8] == branch_bit_set_pkg::OP_NO_OVF)
                || (w[15:8] == branch_bit_set_pkg::OP_NOT_ZERO)
                || (w[15:11] == branch_bit_set_pkg::OP_ALWAYS)
                || (w[15:12] == branch_bit_set_pkg::OP_SET_BIT);
    endfunction

    assign is_nn_w  = have_q && (ir_q[15:8] == branch_bit_set_pkg::OP_NOT_NEG);
    assign is_nov_w = have_q && (ir_q[15:8] == branch_bit_set_pkg::OP_NO_OVF);
    assign is_nz_w  = have_q && (ir_q[15:8] == branch_bit_set_pkg::OP_NOT_ZERO);
    assign is_bra_w = have_q && (ir_q[15:11] == branch_bit_set_pkg::OP_ALWAYS);
    assign is_bsf_w = have_q && (ir_q[15:12] == branch_bit_set_pkg::OP_SET_BIT);

    assign cond_w   = (is_nn_w && !negative_flag_in) || (is_nov_w && !overflow_flag_in)
                   || (is_nz_w && !zero_flag_in) || is_bra_w;
    assign off8_w   = {{12{ir_q[7]}}, ir_q[7:0], 1'b0};
    assign off11_w  = {{9{ir_q[10]}}, ir_q[10:0], 1'b0};
    assign file_w   = ir_q[7:0];
    assign mask_w   = 8'h01 << ir_q[11:9];
    assign accept_w = (qif.phase == branch_bit_set_pkg::PH_Q1)
                   && (state_q == branch_bit_set_pkg::ST_EXEC) && instr_valid_in;
    assign req_w    = avs_read_in || avs_write_in;

    always_comb begin
        addr_w = {bank_q, file_w};
        if (!ir_q[8]) begin
            if (ext_q && (file_w <= branch_bit_set_pkg::INDEXED_MAX)) begin
                addr_w = index_base_in + {4'h0, file_w};
            end else if (file_w < branch_bit_set_pkg::ACCESS_SPLIT) begin
                addr_w = {branch_bit_set_pkg::ACCESS_LO_BNK, file_w};
            end else begin
                addr_w = {branch_bit_set_pkg::ACCESS_HI_BNK, file_w};
            end
        end
    end

    always_comb begin
        state_d  = state_q;
        ir_d     = ir_q;
        have_d   = have_q;
        pc_d     = pc_q;
        target_d = target_q;
        taken_d  = taken_q;
        take_d   = 1'b0;
        maddr_d  = maddr_q;
        mrd_d    = 1'b0;
        mwr_d    = 1'b0;
        mwdata_d = mwdata_q;
        case (qif.phase)
            branch_bit_set_pkg::PH_Q1: begin
                have_d = accept_w;
                take_d = accept_w;
                if (accept_w) begin
                    ir_d = instr_word_in;
                    pc_d = pc_q + branch_bit_set_pkg::PC_STEP;
                end
            end
            branch_bit_set_pkg::PH_Q2: begin
                if (is_bsf_w) begin
                    maddr_d = addr_w;
                    mrd_d   = 1'b1;
                end
            end
            branch_bit_set_pkg::PH_Q3: begin
                if (is_bsf_w) begin
                    mwdata_d = mem_rdata_in | mask_w;
                    mwr_d    = 1'b1;
                end
                taken_d  = cond_w;
                target_d = pc_q + (is_bra_w ? off11_w : off8_w);
            end
            branch_bit_set_pkg::PH_Q4: begin
                if (taken_q && have_q) begin
                    pc_d    = target_q;
                    state_d = branch_bit_set_pkg::ST_FLUSH;
                end else begin
                    state_d = branch_bit_set_pkg::ST_EXEC;
                end
                if (state_q == branch_bit_set_pkg::ST_FLUSH) begin
                    state_d = branch_bit_set_pkg::ST_EXEC;
                end
            end
            default: begin
                have_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_q  <= branch_bit_set_pkg::ST_EXEC;
            ir_q     <= 16'h0000;
            have_q   <= 1'b0;
            pc_q     <= branch_bit_set_pkg::PC_RESET;
            target_q <= branch_bit_set_pkg::PC_RESET;
            taken_q  <= 1'b0;
            take_q   <= 1'b0;
            maddr_q  <= 12'h000;
            mrd_q    <= 1'b0;
            mwr_q    <= 1'b0;
            mwdata_q <= 8'h00;
        end else begin
            state_q  <= state_d;
            ir_q     <= ir_d;
            have_q   <= have_d;
            pc_q     <= pc_d;
            target_q <= target_d;
            taken_q  <= taken_d;
            take_q   <= take_d;
            maddr_q  <= maddr_d;
            mrd_q    <= mrd_d;
            mwr_q    <= mwr_d;
            mwdata_q <= mwdata_d;
        end
    end

    // Avalon slave, one wait cycle per access
    always_comb begin
        wait_d    = 1'b1;
        rdata_d   = rdata_q;
        ext_d     = ext_q;
        bank_d    = bank_q;
        unknown_d = unknown_q;
        if (req_w && wait_q) begin
            wait_d  = 1'b0;
            rdata_d = 32'h0000_0000;
            case (avs_address_in)
                branch_bit_set_pkg::REG_CONTROL: rdata_d[branch_bit_set_pkg::CTRL_EXT_BIT] = ext_q;
                branch_bit_set_pkg::REG_BANK:    rdata_d[3:0] = bank_q;
                branch_bit_set_pkg::REG_STATUS: begin
                    rdata_d[branch_bit_set_pkg::STAT_TAKEN]   = taken_q;
                    rdata_d[branch_bit_set_pkg::STAT_FLUSH]   =
                        (state_q == branch_bit_set_pkg::ST_FLUSH);
                    rdata_d[branch_bit_set_pkg::STAT_UNKNOWN] = unknown_q;
                end
                branch_bit_set_pkg::REG_PC:      rdata_d[20:0] = pc_q;
                default:                         rdata_d = 32'h0000_0000;
            endcase
        end
        if (avs_write_in && !wait_q) begin
            case (avs_address_in)
                branch_bit_set_pkg::REG_CONTROL:
                    ext_d = avs_writedata_in[branch_bit_set_pkg::CTRL_EXT_BIT];
                branch_bit_set_pkg::REG_BANK:    bank_d = avs_writedata_in[3:0];
                branch_bit_set_pkg::REG_STATUS: begin
                    if (avs_writedata_in[branch_bit_set_pkg::STAT_UNKNOWN]) begin
                        unknown_d = 1'b0;
                    end
                end
                default:                         ext_d = ext_q;
            endcase
        end
        if (accept_w && !known_op(instr_word_in)) begin
            unknown_d = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wait_q    <= 1'b1;
            rdata_q   <= 32'h0000_0000;
            ext_q     <= branch_bit_set_pkg::EXT_RESET;
            bank_q    <= branch_bit_set_pkg::BANK_RESET;
            unknown_q <= 1'b0;
        end else begin
            wait_q    <= wait_d;
            rdata_q   <= rdata_d;
            ext_q     <= ext_d;
            bank_q    <= bank_d;
            unknown_q <= unknown_d;
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign q_phase_out         = qif.phase;
    assign fetch_take_out      = take_q;
    assign pc_out              = pc_q;
    assign mem_addr_out        = maddr_q;
    assign mem_rd_out          = mrd_q;
    assign mem_wr_out          = mwr_q;
    assign mem_wdata_out       = mwdata_q;

    nn_taken_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && is_nn_w && !negative_flag_in)
        |-> ##2 (pc_q == $past(pc_q, 2) + 21'(2 * $signed(ir_q[7:0]))))
        else $error("negative clear branch not taken");
    nov_taken_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && is_nov_w && !overflow_flag_in)
        |-> ##2 (pc_q == $past(pc_q, 2) + 21'(2 * $signed(ir_q[7:0]))))
        else $error("overflow clear branch not taken");
    nz_taken_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && is_nz_w && !zero_flag_in)
        |-> ##2 (pc_q == $past(pc_q, 2) + 21'(2 * $signed(ir_q[7:0]))))
        else $error("zero clear branch not taken");
    cond_hold_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && !cond_w)
        |-> ##2 (pc_q == $past(pc_q, 2)))
        else $error("counter moved without taken branch");
    flush_cycle_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q4 && have_q && taken_q)
        |=> (state_q == branch_bit_set_pkg::ST_FLUSH && !take_d)[*4]
        ##1 (state_q == branch_bit_set_pkg::ST_EXEC))
        else $error("taken branch lacks one no operation cycle");
    bra_target_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && is_bra_w)
        |-> ##2 (pc_q == $past(pc_q, 2) + 21'(2 * $signed(ir_q[10:0]))))
        else $error("unconditional branch target wrong");
    set_write_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q3 && is_bsf_w)
        |=> mwr_q && !mrd_q && (mwdata_q == ($past(mem_rdata_in) | (8'h01 << ir_q[11:9])))
        ##1 !mwr_q)
        else $error("bit set write back wrong");
    bank_addr_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q2 && is_bsf_w && ir_q[8])
        |=> mrd_q && (mem_addr_out == {$past(bank_q), $past(file_w)}))
        else $error("banked address wrong");
    indexed_addr_a: assert property (@(posedge clock_in) disable iff (srst_in)
        (qif.phase == branch_bit_set_pkg::PH_Q2 && is_bsf_w && !ir_q[8] && ext_q
         && file_w <= branch_bit_set_pkg::INDEXED_MAX)
        |=> (mem_addr_out == $past(index_base_in) + {4'h0, $past(file_w)}))
        else $error("indexed address wrong");
endmodule
`default_nettype wire

/* File: common/branch_bit_set_pkg.sv */
// Constants, encodings and register map of the branch and bit-set decoder
package branch_bit_set_pkg;
    localparam int          PC_W          = 21;
    localparam int          ADDR_W        = 12;
    localparam int          INSTR_W       = 16;
    localparam int          PHASE_W       = 4;

    localparam logic [3:0]  PH_Q1         = 4'h1;
    localparam logic [3:0]  PH_Q2         = 4'h2;
    localparam logic [3:0]  PH_Q3         = 4'h4;
    localparam logic [3:0]  PH_Q4         = 4'h8;

    localparam logic [7:0]  OP_NOT_NEG    = 8'hE7;
    localparam logic [7:0]  OP_NO_OVF     = 8'hE5;
    localparam logic [7:0]  OP_NOT_ZERO   = 8'hE1;
    localparam logic [4:0]  OP_ALWAYS     = 5'h1A;
    localparam logic [3:0]  OP_SET_BIT    = 4'h8;

    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [7:0]  INDEXED_MAX   = 8'h5F;
    localparam logic [3:0]  ACCESS_LO_BNK = 4'h0;
    localparam logic [3:0]  ACCESS_HI_BNK = 4'hF;
    localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;

    localparam logic [3:0]  REG_CONTROL   = 4'h0;
    localparam logic [3:0]  REG_BANK      = 4'h4;
    localparam logic [3:0]  REG_STATUS    = 4'h8;
    localparam logic [3:0]  REG_PC        = 4'hC;
    localparam int          CTRL_EXT_BIT  = 0;
    localparam int          STAT_TAKEN    = 0;
    localparam int          STAT_FLUSH    = 1;
    localparam int          STAT_UNKNOWN  = 2;
    localparam logic        EXT_RESET     = 1'b0;
    localparam logic [3:0]  BANK_RESET    = 4'h0;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'b01,
        ST_FLUSH = 2'b10
    } seq_state_t;
endpackage

/* File: common/q_phase_if.sv */
// Q phase carrier between the phase generator and the decoder
`timescale 1ns/10ps
`default_nettype none
interface q_phase_if;
    logic [3:0] phase;
    modport gen (output phase);
    modport sink (input phase);
endinterface
`default_nettype wire

/* File: hdl/q_phase_gen.sv */
// Four phase rotator, one Q phase per clock
`timescale 1ns/10ps
`default_nettype none
module q_phase_gen (
    input  wire logic    clock_in,
    input  wire logic    srst_in,
    q_phase_if.gen       qif
);
    logic [3:0] phase_q;
    logic [3:0] phase_d;

    always_comb begin
        phase_d = {phase_q[2:0], phase_q[3]};
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            phase_q <= branch_bit_set_pkg::PH_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign qif.phase = phase_q;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the branch and bit-set decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clock_in;
    logic        srst_in;
    logic [3:0]  avs_address_in;
    logic        avs_read_in;
    logic        avs_write_in;
    logic [31:0] avs_writedata_in;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [15:0] instr_word_in;
    logic        instr_valid_in;
    logic        negative_flag_in;
    logic        overflow_flag_in;
    logic        zero_flag_in;
    logic [11:0] index_base_in;
    logic [7:0]  mem_rdata_in;
    logic [3:0]  q_phase_out;
    logic        fetch_take_out;
    logic [20:0] pc_out;
    logic [11:0] mem_addr_out;
    logic        mem_rd_out;
    logic        mem_wr_out;
    logic [7:0]  mem_wdata_out;
    int          mismatches;
    int          compares;
    int          seed;
    logic [20:0] pc_m;
    logic        ext_m;
    logic [3:0]  bank_m;
    logic        last_taken;
    logic [31:0] rd;
    logic [31:0] rnd;
    logic [2:0]  fl;
    logic [7:0]  off8;
    logic [10:0] off11;
    logic [7:0]  ops [3] = '{8'hE7, 8'hE5, 8'hE1};
    logic [7:0]  ftab [5] = '{8'h5F, 8'h60, 8'h00, 8'hFF, 8'h35};

    branch_bit_set_decode i_dut (
        .clock_in(clock_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .instr_word_in(instr_word_in),
        .instr_valid_in(instr_valid_in), .negative_flag_in(negative_flag_in),
        .overflow_flag_in(overflow_flag_in), .zero_flag_in(zero_flag_in),
        .index_base_in(index_base_in), .mem_rdata_in(mem_rdata_in),
        .q_phase_out(q_phase_out), .fetch_take_out(fetch_take_out), .pc_out(pc_out),
        .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
        .mem_wdata_out(mem_wdata_out)
    );

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end

    task automatic final_report;
        begin
            $display("compares %0d mismatches %0d", compares, mismatches);
            if (mismatches == 0 && compares > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        begin
            compares++;
            if (got !== exp) begin
                mismatches++;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // Wait to mid-cycle of the given phase
    task automatic to_phase(input logic [3:0] ph);
        int n;
        begin
            n = 0;
            do begin
                @(negedge clock_in);
                n++;
            end while (q_phase_out !== ph && n < 9);
            if (q_phase_out !== ph) begin
                mismatches++;
                final_report();
            end
        end
    endtask

    // Avalon access, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge clock_in);
            avs_address_in <= a;
            avs_writedata_in <= d;
            avs_read_in <= !wr;
            avs_write_in <= wr;
            n = 0;
            @(negedge clock_in);
            while (avs_waitrequest_out !== 1'b0 && n < 20) begin
                @(negedge clock_in);
                n++;
            end
            if (avs_waitrequest_out !== 1'b0) begin
                mismatches++;
                final_report();
            end
            @(posedge clock_in);
            rd = avs_readdata_out;
            avs_read_in <= 1'b0;
            avs_write_in <= 1'b0;
        end
    endtask

    // One instruction cycle with model prediction
    task automatic run_instr(input logic [15:0] w, input logic [2:0] f);
        int          off;
        logic        bset;
        logic [11:0] ea;
        logic [11:0] ib;
        logic [7:0]  rdat;
        begin
            to_phase(branch_bit_set_pkg::PH_Q4);
            rdat = 8'($random(seed));
            ib = 12'($random(seed));
            @(posedge clock_in);
            instr_word_in <= w;
            instr_valid_in <= 1'b1;
            {negative_flag_in, overflow_flag_in, zero_flag_in} <= f;
            mem_rdata_in <= rdat;
            index_base_in <= ib;
            bset = (w[15:12] == 4'h8);
            off = int'($signed(w[7:0]));
            case (w[15:8])
                8'hE7: last_taken = !f[2];
                8'hE5: last_taken = !f[1];
                8'hE1: last_taken = !f[0];
                default: last_taken = 1'b0;
            endcase
            if (w[15:11] == 5'h1A) begin
                last_taken = 1'b1;
                off = int'($signed(w[10:0]));
            end
            if (w[8]) ea = {bank_m, w[7:0]};
            else if (ext_m && w[7:0] <= 8'h5F) ea = ib + {4'h0, w[7:0]};
            else ea = {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
            @(negedge clock_in);
            @(posedge clock_in);
            if (!last_taken) instr_valid_in <= 1'b0;
            @(negedge clock_in);
            pc_m = pc_m + 21'h2;
            cmp(32'(fetch_take_out), 32'h1);
            cmp(32'(pc_out), 32'(pc_m));
            @(negedge clock_in);
            cmp(32'(mem_rd_out), 32'(bset));
            if (bset) cmp(32'(mem_addr_out), 32'(ea));
            @(negedge clock_in);
            cmp(32'(mem_wr_out), 32'(bset));
            if (bset) cmp(32'(mem_wdata_out), 32'(rdat | (8'h1 << w[11:9])));
            @(negedge clock_in);
            if (last_taken) pc_m = pc_m + 21'(2 * off);
            cmp(32'(pc_out), 32'(pc_m));
            if (last_taken) begin
                @(posedge clock_in);
                instr_valid_in <= 1'b0;
                @(negedge clock_in);
                cmp(32'(fetch_take_out), 32'h0);
                cmp(32'(pc_out), 32'(pc_m));
            end
        end
    endtask

    initial begin
        repeat (20000) @(posedge clock_in);
        mismatches++;
        final_report();
    end

    initial begin
        seed = 85;
        mismatches = 0;
        compares = 0;
        srst_in = 1'b1;
        avs_address_in = 4'h0;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_writedata_in = 32'h0;
        instr_word_in = 16'h0;
        instr_valid_in = 1'b0;
        {negative_flag_in, overflow_flag_in, zero_flag_in} = 3'h0;
        index_base_in = 12'h0;
        mem_rdata_in = 8'h0;
        pc_m = 21'h0;
        ext_m = 1'b0;
        bank_m = 4'h0;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        @(negedge clock_in);
        cmp(32'(q_phase_out), 32'h1);
        cmp(32'(avs_waitrequest_out), 32'h1);
        for (int i = 0; i < 16; i += 4) begin
            av(1'b0, 4'(i), 32'h0);
            cmp(rd, 32'h0);
        end
        av(1'b1, 4'h2, 32'hFFFFFFFF);
        av(1'b0, 4'h2, 32'h0);
        cmp(rd, 32'h0);
        rnd = $random(seed);
        bank_m = rnd[3:0];
        av(1'b1, 4'h4, rnd);
        av(1'b0, 4'h4, 32'h0);
        cmp(rd, 32'(bank_m));
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 4; k++) begin
                fl = 3'($random(seed));
                fl[2 - i] = k[1];
                off8 = (k == 0) ? 8'h80 : (k == 1) ? 8'h7F : 8'($random(seed));
                run_instr({ops[i], off8}, fl);
                av(1'b0, 4'h8, 32'h0);
                cmp(rd & 32'h1, 32'(last_taken));
                cmp(32'(rd[1]), 32'(last_taken));
            end
        end
        for (int k = 0; k < 4; k++) begin
            off11 = (k == 0) ? 11'h400 : (k == 1) ? 11'h3FF : 11'($random(seed));
            run_instr({5'h1A, off11}, 3'($random(seed)));
        end
        av(1'b0, 4'hC, 32'h0);
        cmp(rd, 32'(pc_m));
        for (int e = 0; e < 2; e++) begin
            ext_m = e[0];
            av(1'b1, 4'h0, 32'(e));
            for (int j = 0; j < 5; j++) begin
                run_instr({4'h8, 3'($random(seed)), (j == 4), ftab[j]}, 3'($random(seed)));
            end
        end
        run_instr(16'hF123, 3'h0);
        av(1'b0, 4'h8, 32'h0);
        cmp(32'(rd[2]), 32'h1);
        av(1'b1, 4'h8, 32'h4);
        av(1'b0, 4'h8, 32'h0);
        cmp(32'(rd[2]), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
